/* pkg/tdm_defines.svh */
`ifndef TDM_DEFINES_SVH
`define TDM_DEFINES_SVH

// Clock and sampling timing
`define TDM_CLK_PERIOD_NS  20
`define TDM_SAMPLE_NS      1000
`define TDM_SAMPLE_CYC     (`TDM_SAMPLE_NS / `TDM_CLK_PERIOD_NS)
`define TDM_HOT_RESP_NS    10000
`define TDM_HOT_RESP_CYC   (`TDM_HOT_RESP_NS / `TDM_CLK_PERIOD_NS)
`define TDM_MIN_ASSERT_NS  187000
`define TDM_OE_HIST        5

// Register byte offsets
`define TDM_CTRL_OFF       8'h00
`define TDM_INTERVAL_OFF   8'h04
`define TDM_LIMIT_OFF      8'h08
`define TDM_CUR1_OFF       8'h10
`define TDM_CUR2_OFF       8'h14
`define TDM_AVG1_OFF       8'h18
`define TDM_AVG2_OFF       8'h1C
`define TDM_BAND_OFF       8'h20
`define TDM_INT_STAT_OFF   8'h24
`define TDM_INT_CLR_OFF    8'h28
`define TDM_INT_EN_OFF     8'h2C
`define TDM_OVR_OFF        8'h30

// Field positions
`define TDM_CTRL_SHORT     0
`define TDM_CTRL_HOTDIS    1
`define TDM_CTRL_SLEEP_LSB 2
`define TDM_OVR_EN         0
`define TDM_OVR_SEL        1
`define TDM_OVR_DUTY_LSB   8

// Band thresholds
`define TDM_BAND_75        8'hC1
`define TDM_BAND_50        8'h81
`define TDM_BAND_25        8'h41
`define TDM_BAND_12        8'h21

// Reset values
`define TDM_CTRL_RST       4'h0
`define TDM_INTERVAL_RST   16'h0100
`define TDM_LIMIT_RST      16'hFFFF
`define TDM_OVR_RST        16'h0000
`define TDM_SYNC_RST       4'h3

`endif

/* pkg/tdm_pkg.sv */
package tdm_pkg;

  typedef enum logic [1:0] {
    TDM_S0  = 2'h0,
    TDM_S3  = 2'h1,
    TDM_S45 = 2'h2
  } tdm_sleep_type;

  typedef enum logic [1:0] {
    TDM_ST_SLEEP = 2'h0,
    TDM_ST_FIRST = 2'h1,
    TDM_ST_RUN   = 2'h3
  } tdm_run_type;

endpackage

/* rtl/tdm_top.sv */
`timescale 1ns/1ps
`include "tdm_defines.svh"

module tdm_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        cpu1_throttle_n_in,
  output logic             cpu1_throttle_n_out,
  output logic             cpu1_throttle_n_oe,
  input  wire logic        cpu2_throttle_n_in,
  output logic             cpu2_throttle_n_out,
  output logic             cpu2_throttle_n_oe,
  input  wire logic [1:0]  regulator_hot_in,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [5:0] SAMPLE_LAST = 6'(`TDM_SAMPLE_CYC - 1);
  localparam int HOT_MAX = 8;

  function automatic logic [7:0] tdm_meas(input logic [8:0] hi, input logic any,
                                         input logic full);
    if (!any) begin
      tdm_meas = 8'h00;
    end else if (full || hi >= 9'h0FF) begin
      tdm_meas = 8'hFF;
    end else begin
      tdm_meas = hi[7:0] + 8'h01;
    end
  endfunction

  function automatic logic [7:0] tdm_band(input logic [7:0] v, input logic full,
                                         input logic [7:0] lim);
    tdm_band[0] = full;
    tdm_band[1] = (v >= `TDM_BAND_75) && !full;
    tdm_band[2] = (v >= `TDM_BAND_50) && (v < `TDM_BAND_75);
    tdm_band[3] = (v >= `TDM_BAND_25) && (v < `TDM_BAND_50);
    tdm_band[4] = (v >= `TDM_BAND_12) && (v < `TDM_BAND_25);
    tdm_band[5] = (v != 8'h00) && (v < `TDM_BAND_12);
    tdm_band[6] = (v != 8'h00);
    tdm_band[7] = (v > lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [3:0]          ctrl_reg;
  logic [15:0]         interval_reg;
  logic [15:0]         limit_reg;
  logic [15:0]         ovr_reg;
  logic [15:0]         band_reg;
  logic [15:0]         int_stat_reg;
  logic [15:0]         int_en_reg;
  logic [7:0]          cur_reg [2];
  logic [7:0]          avg_reg [2];
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic [3:0]          sync1_reg;
  logic [3:0]          sync2_reg;
  logic [3:0]          sync3_reg;
  logic [3:0]          filt_reg;
  logic [5:0]          samp_cnt_reg;
  logic [15:0]         slot_cnt_reg;
  logic [7:0]          slot_idx_reg;
  logic [7:0]          pwm_cnt_reg;
  logic [15:0]         acc_lo_reg [2];
  logic [8:0]          acc_hi_reg [2];
  logic [1:0]          any_reg;
  logic [1:0]          off_reg;
  logic [`TDM_OE_HIST-1:0] oe_hist_reg [2];
  tdm_pkg::tdm_run_type run_reg;

  logic [15:0]         acc_lo_next [2];
  logic [8:0]          acc_hi_next [2];
  logic [1:0]          any_next;
  logic [1:0]          off_next;
  logic [7:0]          meas [2];
  logic [15:0]         band_next;
  logic [31:0]         rd_next;
  logic [1:0]          drv_next;

  logic                ap_valid;
  logic                sleep;
  logic                tick;
  logic                running;
  logic [1:0]          cur_wr;
  logic                restart;
  logic                end_iv;
  logic [15:0]         slot_len;
  logic [1:0]          thr_act;
  logic [1:0]          hot_act;
  logic [1:0]          hot_drv;
  logic [1:0]          ext;
  logic                ovr_on;
  logic                short_en;
  logic [15:0]         int_clr;

  assign ap_valid = hsel && hready && htrans[1];
  assign sleep    = ctrl_reg[`TDM_CTRL_SLEEP_LSB +: 2] != tdm_pkg::TDM_S0;
  assign short_en = ctrl_reg[`TDM_CTRL_SHORT];
  assign tick     = samp_cnt_reg == SAMPLE_LAST;
  assign running  = !sleep && run_reg != tdm_pkg::TDM_ST_SLEEP;
  assign cur_wr[0] = wr_pend_reg && wr_addr_reg == `TDM_CUR1_OFF;
  assign cur_wr[1] = wr_pend_reg && wr_addr_reg == `TDM_CUR2_OFF;
  assign restart  = (|cur_wr) || sleep;
  assign slot_len = (interval_reg == 16'h0000) ? 16'h0001 : interval_reg;
  assign end_iv   = tick && running && !(|cur_wr) && slot_idx_reg == 8'hFF
                    && slot_cnt_reg == slot_len - 16'h0001;
  assign thr_act  = ~filt_reg[1:0];
  assign hot_act  = filt_reg[3:2];
  assign int_clr  = (wr_pend_reg && wr_addr_reg == `TDM_INT_CLR_OFF) ? hwdata[15:0] : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change is taken once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= `TDM_SYNC_RST;
      sync2_reg <= `TDM_SYNC_RST;
      sync3_reg <= `TDM_SYNC_RST;
      filt_reg  <= `TDM_SYNC_RST;
    end else begin
      sync1_reg <= {regulator_hot_in, cpu2_throttle_n_in, cpu1_throttle_n_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 4; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          filt_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (haddr[7:0])
      `TDM_CTRL_OFF:     rd_next[3:0]  = ctrl_reg;
      `TDM_INTERVAL_OFF: rd_next[15:0] = interval_reg;
      `TDM_LIMIT_OFF:    rd_next[15:0] = limit_reg;
      `TDM_CUR1_OFF:     rd_next[7:0]  = cur_reg[0];
      `TDM_CUR2_OFF:     rd_next[7:0]  = cur_reg[1];
      `TDM_AVG1_OFF:     rd_next[7:0]  = avg_reg[0];
      `TDM_AVG2_OFF:     rd_next[7:0]  = avg_reg[1];
      `TDM_BAND_OFF:     rd_next[15:0] = band_reg;
      `TDM_INT_STAT_OFF: rd_next[15:0] = int_stat_reg;
      `TDM_INT_EN_OFF:   rd_next[15:0] = int_en_reg;
      `TDM_OVR_OFF:      rd_next[15:0] = ovr_reg;
      default:           rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= ap_valid && hwrite;
      wr_addr_reg <= haddr[7:0];
      hrdata      <= (ap_valid && !hwrite) ? rd_next : 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= `TDM_CTRL_RST;
      interval_reg <= `TDM_INTERVAL_RST;
      limit_reg    <= `TDM_LIMIT_RST;
      ovr_reg      <= `TDM_OVR_RST;
      int_en_reg   <= 16'h0000;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `TDM_CTRL_OFF:     ctrl_reg     <= hwdata[3:0];
        `TDM_INTERVAL_OFF: interval_reg <= hwdata[15:0];
        `TDM_LIMIT_OFF:    limit_reg    <= hwdata[15:0];
        `TDM_OVR_OFF:      ovr_reg      <= hwdata[15:0];
        `TDM_INT_EN_OFF:   int_en_reg   <= hwdata[15:0];
        default:           ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interval timing: 256 slots of interval_reg samples, one sample per microsecond
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_cnt_reg <= 6'h00;
    end else begin
      samp_cnt_reg <= tick ? 6'h00 : samp_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_cnt_reg <= 16'h0000;
      slot_idx_reg <= 8'h00;
    end else if (restart || !running) begin
      slot_cnt_reg <= 16'h0000;
      slot_idx_reg <= 8'h00;
    end else if (tick) begin
      if (slot_cnt_reg == slot_len - 16'h0001) begin
        slot_cnt_reg <= 16'h0000;
        slot_idx_reg <= slot_idx_reg + 8'h01;
      end else begin
        slot_cnt_reg <= slot_cnt_reg + 16'h0001;
      end
    end
  end

  // Asserted samples divide by the slot length in a wrap counter, avoiding a divider
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      acc_lo_next[i] = acc_lo_reg[i];
      acc_hi_next[i] = acc_hi_reg[i];
      any_next[i]    = any_reg[i] || (tick && thr_act[i]);
      off_next[i]    = off_reg[i] || (tick && !thr_act[i]);
      if (tick && thr_act[i]) begin
        if (acc_lo_reg[i] + 16'h0001 == slot_len) begin
          acc_lo_next[i] = 16'h0000;
          acc_hi_next[i] = acc_hi_reg[i] + 9'h001;
        end else begin
          acc_lo_next[i] = acc_lo_reg[i] + 16'h0001;
        end
      end
      meas[i] = tdm_meas(acc_hi_next[i], any_next[i], !off_next[i]);
      band_next[i*8 +: 8] = tdm_band(meas[i], !off_next[i], limit_reg[i*8 +: 8]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        acc_lo_reg[i] <= 16'h0000;
        acc_hi_reg[i] <= 9'h000;
      end
      any_reg <= 2'b00;
      off_reg <= 2'b00;
    end else if (restart || end_iv || !running) begin
      for (int i = 0; i < 2; i++) begin
        acc_lo_reg[i] <= 16'h0000;
        acc_hi_reg[i] <= 9'h000;
      end
      any_reg <= 2'b00;
      off_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        acc_lo_reg[i] <= acc_lo_next[i];
        acc_hi_reg[i] <= acc_hi_next[i];
      end
      any_reg <= any_next;
      off_reg <= off_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep sequencing and result registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= tdm_pkg::TDM_ST_FIRST;
    end else if (sleep) begin
      run_reg <= tdm_pkg::TDM_ST_SLEEP;
    end else begin
      unique case (run_reg)
        tdm_pkg::TDM_ST_SLEEP: run_reg <= tdm_pkg::TDM_ST_FIRST;
        tdm_pkg::TDM_ST_FIRST: run_reg <= end_iv ? tdm_pkg::TDM_ST_RUN : tdm_pkg::TDM_ST_FIRST;
        tdm_pkg::TDM_ST_RUN:   run_reg <= tdm_pkg::TDM_ST_RUN;
        default:               run_reg <= tdm_pkg::TDM_ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        cur_reg[i] <= 8'h00;
        avg_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sleep) begin
          cur_reg[i] <= 8'h00;
        end else if (cur_wr[i]) begin
          cur_reg[i] <= hwdata[7:0];
        end else if (end_iv) begin
          cur_reg[i] <= meas[i];
          if (run_reg == tdm_pkg::TDM_ST_FIRST) begin
            avg_reg[i] <= meas[i];
          end else begin
            avg_reg[i] <= 8'(({1'b0, avg_reg[i]} + {1'b0, cur_reg[i]}) >> 1);
          end
        end
      end
    end
  end

  // Band bits feed sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      band_reg     <= 16'h0000;
      int_stat_reg <= 16'h0000;
      irq          <= 1'b0;
    end else begin
      if (end_iv) begin
        band_reg <= band_next;
      end
      int_stat_reg <= (int_stat_reg & ~int_clr) | (end_iv ? band_next : 16'h0000);
      irq          <= |(int_stat_reg & int_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_cnt_reg <= 8'h00;
    end else if (tick) begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  assign ovr_on  = ovr_reg[`TDM_OVR_EN] && (pwm_cnt_reg < ovr_reg[`TDM_OVR_DUTY_LSB +: 8]);
  assign hot_drv = hot_act & {2{!sleep && !ctrl_reg[`TDM_CTRL_HOTDIS]}};
  // Our own release echoes back through the synchroniser; masking recent drive
  // keeps the mirror from latching itself, at the cost of missing an outside
  // assertion that starts while we drive the same line.
  assign ext[0]  = thr_act[0] && !(|oe_hist_reg[0]);
  assign ext[1]  = thr_act[1] && !(|oe_hist_reg[1]);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      drv_next[i] = hot_drv[i]
                    || (ovr_on && ovr_reg[`TDM_OVR_SEL] == 1'(i))
                    || (short_en && (|hot_drv || ovr_on || ext[1-i]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu1_throttle_n_oe  <= 1'b0;
      cpu2_throttle_n_oe  <= 1'b0;
      cpu1_throttle_n_out <= 1'b0;
      cpu2_throttle_n_out <= 1'b0;
      oe_hist_reg[0]      <= '0;
      oe_hist_reg[1]      <= '0;
    end else begin
      cpu1_throttle_n_oe  <= drv_next[0];
      cpu2_throttle_n_oe  <= drv_next[1];
      cpu1_throttle_n_out <= 1'b0;
      cpu2_throttle_n_out <= 1'b0;
      oe_hist_reg[0]      <= {oe_hist_reg[0][`TDM_OE_HIST-2:0], cpu1_throttle_n_oe};
      oe_hist_reg[1]      <= {oe_hist_reg[1][`TDM_OE_HIST-2:0], cpu2_throttle_n_oe};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_cur_load: assert property (end_iv |=> cur_reg[0] == $past(meas[0]))
    else $error("current value not loaded at interval end");
  a_avg_update: assert property (end_iv && run_reg == tdm_pkg::TDM_ST_RUN |=>
      avg_reg[1] == 8'(({1'b0, $past(avg_reg[1])} + {1'b0, $past(cur_reg[1])}) >> 1))
    else $error("average not old average plus old current halved");
  a_restart_both: assert property (cur_wr[0] && !sleep |=> slot_idx_reg == 8'h00
      && slot_cnt_reg == 16'h0000 && acc_hi_reg[1] == 9'h000)
    else $error("current write did not restart both channels");
  a_nonzero_meas: assert property (end_iv && any_next[0] |=> cur_reg[0] != 8'h00)
    else $error("asserted line measured as zero");
  a_full_band: assert property (end_iv && !off_next[0] |=> band_reg[0] && !band_reg[1])
    else $error("full throttle band wrong");
  a_low_band: assert property (end_iv && meas[1] == 8'h20 |=> band_reg[13] && band_reg[14])
    else $error("lowest band not flagged");
  a_limit_bit: assert property (end_iv |=> band_reg[7] == ($past(meas[0]) > $past(limit_reg[7:0])))
    else $error("user limit bit wrong");
  a_sleep_clear: assert property (sleep |=> cur_reg[0] == 8'h00 && $stable(avg_reg[0]))
    else $error("sleep did not clear current or hold average");
  a_first_direct: assert property (end_iv && run_reg == tdm_pkg::TDM_ST_FIRST |=>
      avg_reg[0] == cur_reg[0] && run_reg == tdm_pkg::TDM_ST_RUN)
    else $error("first result not loaded directly");
  a_hot_drive: assert property ($rose(regulator_hot_in[0]) && !sleep
      && !ctrl_reg[`TDM_CTRL_HOTDIS] ##1 (regulator_hot_in[0] && !sleep)[*4]
      |-> ##[0:HOT_MAX] cpu1_throttle_n_oe)
    else $error("regulator hot not driven onto line");
  a_short_both: assert property (short_en && (|hot_drv) |=> cpu1_throttle_n_oe
      && cpu2_throttle_n_oe)
    else $error("short option did not drive both lines");
  a_hot_suppress: assert property (sleep && !short_en && !ovr_reg[`TDM_OVR_EN] |=>
      !cpu1_throttle_n_oe && !cpu2_throttle_n_oe)
    else $error("hot response not suppressed in sleep");

  c_interval_end: cover property (end_iv && run_reg == tdm_pkg::TDM_ST_RUN);
  c_mirror:       cover property (short_en && ext[0] ##1 cpu2_throttle_n_oe);
  c_override:     cover property (ovr_on ##1 (cpu1_throttle_n_oe || cpu2_throttle_n_oe));
  c_irq:          cover property ($rose(irq));

endmodule // tdm_top

/* tb/tdm_cpu_model.sv */
`timescale 1ns/1ps
`include "tdm_defines.svh"
module tdm_cpu_model #(
  parameter int MIN_CYC = `TDM_MIN_ASSERT_NS / `TDM_CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  req,
  input  wire logic [31:0] dur,
  input  wire logic        oe1,
  input  wire logic        oe2,
  output logic             line1_n,
  output logic             line2_n
);
  logic [31:0] cnt1;
  logic [31:0] cnt2;
  logic [31:0] len;
  // A processor never lets go early, so short requests are stretched
  assign len = (dur < MIN_CYC) ? MIN_CYC : dur;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt1 <= 32'h0;
    else if (req[0]) cnt1 <= len;
    else if (cnt1 != 32'h0) cnt1 <= cnt1 - 32'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt2 <= 32'h0;
    else if (req[1]) cnt2 <= len;
    else if (cnt2 != 32'h0) cnt2 <= cnt2 - 32'h1;
  end
  // Pulled-up wires: low while either party pulls them down
  assign line1_n = !(oe1 || cnt1 != 32'h0);
  assign line2_n = !(oe2 || cnt2 != 32'h0);
endmodule // tdm_cpu_model

/* tb/throttle_duty_monitor_test.sv */
`timescale 1ns/1ps
`include "tdm_defines.svh"
module throttle_duty_monitor_test;
  localparam logic [7:0] LIM1 = 8'h80;
  localparam logic [7:0] LIM2 = 8'hF0;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        o1;
  logic        o2;
  logic        l1_n;
  logic        l2_n;
  logic        oe1;
  logic        oe2;
  logic [1:0]  hot;
  logic        irq;
  logic [1:0]  req;
  logic [31:0] dur;
  int          err_total;
  int          comparisons;
  int          cyc;
  int          t0;
  tdm_top u_tdm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu1_throttle_n_in(l1_n),
    .cpu1_throttle_n_out(o1), .cpu1_throttle_n_oe(oe1), .cpu2_throttle_n_in(l2_n),
    .cpu2_throttle_n_out(o2), .cpu2_throttle_n_oe(oe2), .regulator_hot_in(hot), .irq(irq));
  tdm_cpu_model u_tdm_cpu_model (.clk(hclk), .rst_n(hresetn), .req(req), .dur(dur),
    .oe1(oe1), .oe2(oe2), .line1_n(l1_n), .line2_n(l2_n));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Sampling phase and synchronizer lag shift partial counts by a step or two
  task automatic near(input string nm, input int e, input logic [31:0] g, input int tol);
    int t;
    t = (e == 0 || e == 255) ? 0 : tol;
    comparisons++;
    if ((^g) === 1'bx || int'(g) > e + t || int'(g) < e - t) begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0, v);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask
  task automatic hold(input logic [1:0] w, input int n);
    req <= w;
    dur <= n;
    @(posedge hclk);
    req <= 2'h0;
  endtask
  task automatic wait_to(input int us);
    while (cyc - t0 < us * 50) @(posedge hclk);
  endtask
  task automatic wait_oe(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (((w == 1) ? oe1 : oe2) !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk($sformatf("oe%0d", w), {31'h0, v}, {31'h0, (w == 1) ? oe1 : oe2});
  endtask
  function automatic logic [7:0] band(input logic [7:0] v, input logic f, input logic [7:0] l);
    band = {v > l, v != 8'h00, v != 8'h00 && v < `TDM_BAND_12,
            v >= `TDM_BAND_12 && v < `TDM_BAND_25, v >= `TDM_BAND_25 && v < `TDM_BAND_50,
            v >= `TDM_BAND_50 && v < `TDM_BAND_75, v >= `TDM_BAND_75 && !f, f};
  endfunction
  function automatic logic [7:0] avg(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y};
    avg = s[8:1];
  endfunction
  task automatic ivl(input int e1, input int e2, input logic f2, input logic first,
                     input logic [7:0] ea1, input logic [7:0] ea2,
                     output logic [7:0] c1, output logic [7:0] c2);
    logic [31:0] d;
    rd(`TDM_CUR1_OFF, d);
    c1 = d[7:0];
    near("cur1", e1, d, 3);
    rd(`TDM_CUR2_OFF, d);
    c2 = d[7:0];
    near("cur2", e2, d, 3);
    rc("avg1", `TDM_AVG1_OFF, {24'h0, first ? c1 : ea1});
    rc("avg2", `TDM_AVG2_OFF, {24'h0, first ? c2 : ea2});
    rc("band", `TDM_BAND_OFF, {16'h0, band(c2, f2, LIM2), band(c1, 1'b0, LIM1)});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (120000) @(posedge hclk);
    err_total++;
    summarize();
  end
  initial begin
    logic [7:0] c1a, c2a, c1b, c2b, c1c, c2c;
    int da;
    int dv;
    int n1;
    int n2;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, hot, req, dur} = '0;
    {cyc, t0, err_total, comparisons} = '0;
    void'($urandom(32'h3A15CA14));
    da = 195 + $urandom % 30;
    dv = 64 + $urandom % 128;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rc("ctrl", `TDM_CTRL_OFF, 32'h0);
    rc("interval", `TDM_INTERVAL_OFF, 32'h00000100);
    rc("limit", `TDM_LIMIT_OFF, 32'h0000FFFF);
    rc("ovr", `TDM_OVR_OFF, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rc("unmapped", 8'h3C, 32'h0);
    wr(`TDM_INTERVAL_OFF, 32'h1);
    wr(`TDM_LIMIT_OFF, {16'h0, LIM2, LIM1});
    wr(`TDM_INT_EN_OFF, 32'h00000100);
    hold(2'h2, 326 * 50);
    repeat (500) @(posedge hclk);
    wr(`TDM_CUR1_OFF, 32'h0);
    t0 = cyc;
    wait_to(20);
    hold(2'h1, da * 50);
    wait_to(259);
    ivl(da + 1, 255, 1'b1, 1'b1, 8'h00, 8'h00, c1a, c2a);
    chk("irq", 32'h1, {31'h0, irq});
    rc("stat", `TDM_INT_STAT_OFF, {16'h0, band(c2a, 1'b1, LIM2), band(c1a, 1'b0, LIM1)});
    wr(`TDM_INT_CLR_OFF, 32'h0000FFFF);
    rc("stat", `TDM_INT_STAT_OFF, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`TDM_AVG1_OFF, 32'h00000055);
    rc("avg1", `TDM_AVG1_OFF, {24'h0, c1a});
    wait_to(492);
    hold(2'h1, 190 * 50);
    wait_to(515);
    ivl(21, 61, 1'b0, 1'b0, c1a, 8'hFF, c1b, c2b);
    rc("stat", `TDM_INT_STAT_OFF, {16'h0, band(c2b, 1'b0, LIM2), band(c1b, 1'b0, LIM1)});
    chk("irq", 32'h0, {31'h0, irq});
    wait_to(771);
    ivl(171, 0, 1'b0, 1'b0, avg(c1a, c1b), avg(8'hFF, c2b), c1c, c2c);
    hot <= 2'h1;
    wait_oe(1, 1'b1, 500);
    chk("oe2", 32'h0, {31'h0, oe2});
    hot <= 2'h0;
    wait_oe(1, 1'b0, 500);
    wr(`TDM_CTRL_OFF, 32'h2);
    hot <= 2'h2;
    repeat (600) @(posedge hclk);
    chk("oe2", 32'h0, {31'h0, oe2});
    for (int s = 1; s <= 2; s++) begin
      wr(`TDM_CTRL_OFF, s << `TDM_CTRL_SLEEP_LSB);
      hot <= 2'h3;
      repeat (600) @(posedge hclk);
      chk("oe_sleep", 32'h0, {30'h0, oe2, oe1});
    end
    hot <= 2'h0;
    hold(2'h1, 26500);
    repeat (13000) @(posedge hclk);
    rc("cur1", `TDM_CUR1_OFF, 32'h0);
    rc("cur2", `TDM_CUR2_OFF, 32'h0);
    rc("avg1", `TDM_AVG1_OFF, {24'h0, avg(c1a, c1b)});
    rc("avg2", `TDM_AVG2_OFF, {24'h0, avg(8'hFF, c2b)});
    wr(`TDM_CTRL_OFF, 32'h0);
    repeat (13100) @(posedge hclk);
    rc("cur1", `TDM_CUR1_OFF, 32'h000000FF);
    rc("avg1", `TDM_AVG1_OFF, 32'h000000FF);
    repeat (600) @(posedge hclk);
    // Lines stay separate in this bench, so the short option is safe to set
    wr(`TDM_CTRL_OFF, 32'h1);
    hot <= 2'h2;
    wait_oe(1, 1'b1, 500);
    wait_oe(2, 1'b1, 500);
    hot <= 2'h0;
    wait_oe(1, 1'b0, 500);
    wait_oe(2, 1'b0, 500);
    hold(2'h1, 0);
    wait_oe(2, 1'b1, 500);
    repeat (4000) @(posedge hclk);
    chk("mirror", 32'h2, {30'h0, oe2, oe1});
    wait_oe(2, 1'b0, 6000);
    wr(`TDM_OVR_OFF, {16'h0, dv[7:0], 8'h03});
    n1 = 0;
    n2 = 0;
    repeat (12800) begin
      @(posedge hclk);
      if (oe1 === 1'b1) n1++;
      if (oe2 === 1'b1) n2++;
    end
    near("ovr2", dv * 50, n2, 60);
    near("ovr1", dv * 50, n1, 60);
    wr(`TDM_OVR_OFF, 32'h0);
    repeat (20) @(posedge hclk);
    chk("oe_off", 32'h0, {28'h0, o2, o1, oe2, oe1});
    summarize();
  end
endmodule // throttle_duty_monitor_test
